/* File: testbench/dp_master.sv */
// Fieldbus master model, one-cycle requests
`default_nettype none
module dp_master (
    input  wire logic       mclk,      // Clock
    output var  logic       ssa_valid, // Set address
    output var  logic [6:0] ssa_addr,  // New address
    output var  logic       prm_valid, // Record
    output var  logic [3:0] prm_len,   // Record length
    output var  logic       diag_req,  // Diag request
    output var  logic       operate,   // Operate state
    output var  logic       dx_req     // Exchange request
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {ssa_valid, ssa_addr, prm_valid, prm_len, diag_req, operate, dx_req} = '0;
    // ====
    // Kind 0 address, 1 record, 2 diag, 3 exchange; operate stays once entered
    task req(input int k, input logic [6:0] v);
        ssa_addr <= v;
        prm_len <= v[3:0];
        if (k == 3) operate <= 1'b1;
        {dx_req, diag_req, prm_valid, ssa_valid} <= 4'h1 << k;
        @(posedge mclk);
        {dx_req, diag_req, prm_valid, ssa_valid} <= 4'h0;
        @(posedge mclk);
    endtask : req
endmodule : dp_master
`default_nettype wire

/* File: testbench/fbs_sup_assertions.sv */
// Port-level checker of the supervisor
`default_nettype none
module fbs_sup_chk (
    input wire logic       mclk,         // Clock
    input wire logic       rst_n,        // Reset
    input wire logic       ce,           // Enable
    input wire logic       ssa_valid,    // Set address
    input wire logic [6:0] ssa_addr,     // Requested address
    input wire logic [6:0] slave_addr,   // Active address
    input wire logic       nvm_we,       // Store pulse
    input wire logic [6:0] nvm_wdata,    // Stored address
    input wire logic       prm_valid,    // Record
    input wire logic [3:0] prm_len,      // Record length
    input wire logic       prm_ok,       // Accepted
    input wire logic       dx_enable,    // Exchange allowed
    input wire logic       diag_req,     // Diag request
    input wire logic       diag_refresh, // Diag refresh
    input wire logic       operate,      // Operate state
    input wire logic       dx_req,       // Exchange request
    input wire logic       laser_on,     // Laser enable
    input wire logic [5:0] diag_len,     // Diag length
    input wire logic [7:0] diag_hdr,     // Header code
    input wire logic       disp_err      // Display
);
    timeunit 1ns;
    timeprecision 1ps;
    // ====
    // Properties
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_ssa_ok; ce && ssa_valid && ssa_addr <= 7'h7d; endsequence
    property p_ssa_ok; s_ssa_ok |=> nvm_we && slave_addr == $past(ssa_addr); endproperty
    a_ssa_ok: assert property (p_ssa_ok) else $error("address lost");
    property p_ssa_bad; ce && ssa_valid && ssa_addr > 7'h7d |=> !nvm_we && $stable(slave_addr);
    endproperty
    a_ssa_bad: assert property (p_ssa_bad) else $error("bad address taken");
    property p_nvm; nvm_we |-> nvm_wdata == slave_addr; endproperty
    a_nvm: assert property (p_nvm) else $error("stored address differs");
    property p_prm; ce && prm_valid && prm_len == 4'h7 |=> prm_ok; endproperty
    a_prm: assert property (p_prm) else $error("short record refused");
    property p_dx; dx_enable |-> prm_ok; endproperty
    a_dx: assert property (p_dx) else $error("early exchange");
    property p_refresh; ce && diag_req |-> ##[1:2] diag_refresh; endproperty
    a_refresh: assert property (p_refresh) else $error("no refresh");
    property p_laser; ce && operate && dx_req && prm_ok |-> ##[1:3] laser_on; endproperty
    a_laser: assert property (p_laser) else $error("laser off");
    property p_len; diag_len == 6'h06 || diag_len == 6'h10 || diag_len == 6'h3d; endproperty
    a_len: assert property (p_len) else $error("bad diag length");
    property p_hdr; (diag_len == 6'h3d) == (diag_hdr == 8'h37); endproperty
    a_hdr: assert property (p_hdr) else $error("bad header");
    property p_disp; !disp_err; endproperty
    a_disp: assert property (p_disp) else $error("error shown");
endmodule : fbs_sup_chk
bind fbs_supervisor fbs_sup_chk fbs_sup_chk_i (.*);
`default_nettype wire

/* File: testbench/testbench.sv */
// Self-checking bench of the supervisor
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, rst_n, ce, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic s_arvalid, s_arready, s_rvalid, s_rready, ssa_valid, nvm_we, nvm_load, prm_valid;
    logic prm_ok, dx_enable, laser_on, laser_retry, diag_send, diag_alarm, diag_refresh;
    logic diag_req, operate, dx_req, laser_alarm, laser_warn, laser_err, wdog_rst, disp_err;
    logic [7:0] s_awaddr, s_araddr, diag_hdr;
    logic [31:0] s_wdata, s_rdata, mfreq, rd_data;
    logic [3:0] s_wstrb, prm_len;
    logic [1:0] s_bresp, s_rresp, trk_mode, rd_resp;
    logic [6:0] ssa_addr, nvm_addr, slave_addr, nvm_wdata, exp_addr, a;
    logic [5:0] diag_len;
    logic [2:0] task_kick;
    logic [4:0] rst_cause;
    logic signed [31:0] dist_raw, dist_out;
    fbs_pkg::prm_t prm_user;
    fbs_pkg::fwd_t fwd_in, fwd_out;
    int num_errors = 0, n_checks = 0, cycles = 0, seed = 32'h4c8c;
    fbs_supervisor fbs_supervisor_i (.*);
    dp_master dp_master_i (.*);
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // ====
    // Kicks, timeout and tasks
    always @(posedge mclk) begin
        task_kick <= 3'($random(seed));
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            conclude();
        end
    end
    task cmp(input string n, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : cmp
    task axi(input logic w, input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
        {s_awaddr, s_araddr, s_wdata} <= {ad, ad, d};
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} <= {w, w, w, !w, !w};
        do begin
            @(posedge mclk);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
            if (s_arready) s_arvalid <= 1'b0;
        end while ((w ? s_bvalid : s_rvalid) !== 1'b1);
        {rd_data, rd_resp} = {s_rdata, w ? s_bresp : s_rresp};
        {s_bready, s_rready} <= 2'b00;
        cmp("resp", er, rd_resp);
        if (!w) cmp("rdata", d, rd_data);
        @(posedge mclk);
    endtask : axi
    task conclude();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude
    initial begin
        {rst_n, nvm_load, nvm_addr, laser_warn, laser_err, laser_alarm, rst_cause} = '0;
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, s_awaddr, s_araddr} = '0;
        {s_wdata, dist_raw, prm_user, fwd_in} = '0;
        {ce, s_wstrb, exp_addr} = {1'b1, 4'hf, 7'h7e};
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        axi(0, fbs_pkg::REG_WDOG_CNT, 0, fbs_pkg::RESP_OKAY);
        axi(0, fbs_pkg::REG_PRM_WIN, 0, fbs_pkg::RESP_SLVERR);
        axi(0, 8'h3c, 0, fbs_pkg::RESP_SLVERR);
        axi(1, fbs_pkg::REG_CTRL, 32'h1, fbs_pkg::RESP_OKAY);
        axi(1, fbs_pkg::REG_STATUS, 32'h1, fbs_pkg::RESP_SLVERR);
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            a = (i < 3) ? 7'h7d + 7'(i) : 7'($random(seed));
            if (a <= 7'h7d) exp_addr = a;
            dp_master_i.req(0, a);
            cmp("slave_addr", 32'(exp_addr), 32'(slave_addr));
            cmp("nvm_wdata", 32'(exp_addr), 32'(nvm_wdata));
        end
        $display("test address done");
        dist_raw <= $random(seed);
        dp_master_i.req(1, 7'h07);
        cmp("prm_ok", 1, 32'(prm_ok));
        dp_master_i.req(2, 7'h00);
        cmp("diag_len", 6, 32'(diag_len));
        dp_master_i.req(3, 7'h00);
        cmp("laser_on", 1, 32'(laser_on));
        repeat (3) @(posedge mclk);
        cmp("dist_out", dist_raw, dist_out);
        $display("test exchange done");
        laser_alarm <= 1'b1;
        @(posedge mclk);
        laser_alarm <= 1'b0;
        axi(0, fbs_pkg::REG_ALARM_CNT, 1, fbs_pkg::RESP_OKAY);
        for (int i = 0; i < 5; i++) begin
            rst_cause <= 5'h01 << i;
            @(posedge mclk);
            rst_cause <= 5'h00;
            @(posedge mclk);
        end
        // Power-on lane counts the initial reset
        axi(0, fbs_pkg::REG_RST_CNT0, 32'h0001_0101, fbs_pkg::RESP_OKAY);
        axi(0, fbs_pkg::REG_RST_CNT1, 32'h0001_0101, fbs_pkg::RESP_OKAY);
        $display("test counters done");
        conclude();
    end
endmodule : testbench
`default_nettype wire

/* File: verilog/event_counter.sv */
// Saturating event counters, one lane per source
`default_nettype none
module event_counter #(
    parameter int unsigned N = 6
) (
    input  wire logic           mclk,   // Clock
    input  wire logic           rst_n,  // Async reset
    input  wire logic           ce,     // Clock enable
    input  wire logic [N-1:0]   hit,    // Event pulses
    output var  logic [8*N-1:0] cnt     // Packed counts
);
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_lane
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    cnt[8*i +: 8] <= 8'h00;
                end else if (ce && hit[i] && cnt[8*i +: 8] != 8'hff) begin
                    cnt[8*i +: 8] <= cnt[8*i +: 8] + 8'h01;
                end
            end
        end
    endgenerate
endmodule : event_counter
`default_nettype wire

/* File: verilog/fbs_pkg.sv */
// Constants, register map and carrier types of the supervisor
// Summary of operation
// - Unserviced 500 ms watchdog resets the module.
// - Main loop, laser control and update each kick the watchdog.
// - Each watchdog reset adds one to its counter; operation restarts.
// - Other reset causes are counted per cause.
// - Slave address assignable 0..125 only; master avoids duplicates.
// - Valid set-address takes effect and is stored non-volatile.
// - A 7-byte standard record is accepted with default settings.
// - Received parameters cannot be read back.
// - Diagnostic length 6, 16 (class 1) or 61 (class 2) bytes.
// - Interval 0 sends on alarm only, n every n x 100 ms.
// - Each diagnostic request refreshes general diagnostics.
// - Class 2 with commissioning: errors and warnings raise alarms.
// - Each laser alarm is reported once and counted, not stored.
// - A reported error retries laser reactivation.
// - Operate state and exchange request switch the laser on.
// - Scale factor within +-1000.000 and offset correct the distance.
// - Measure frequency 0.0..200.0; zero means free running.
// - Error mode selects the distance output during errors.
// - Tracking mode picks one of three; trigger values pass unchanged.
// - Three switched-output thresholds are forwarded to the laser.
// - External errors are never shown locally.
// - Extended header length code: 0x0a class 1, 0x37 class 2.
`default_nettype none
package fbs_pkg;
    // ==========================================================
    // Timing
    localparam int unsigned CLK_HZ         = 40_000_000;
    localparam int unsigned WDOG_MS        = 500;
    localparam int unsigned TICK_MS        = 100;
    localparam int unsigned WDOG_CYC       = CLK_HZ / 1000 * WDOG_MS;
    localparam int unsigned TICK_CYC       = CLK_HZ / 1000 * TICK_MS;
    // ==========================================================
    // Protocol limits
    localparam logic [6:0]  ADDR_MAX       = 7'h7d;
    localparam logic [6:0]  ADDR_RST       = 7'h7e;
    localparam logic [13:0] DIAG_IVL_MAX   = 14'h2710;
    localparam logic [5:0]  DIAG_LEN_STD   = 6'h06;
    localparam logic [5:0]  DIAG_LEN_C1    = 6'h10;
    localparam logic [5:0]  DIAG_LEN_C2    = 6'h3d;
    localparam logic [7:0]  HDR_C1         = 8'h0a;
    localparam logic [7:0]  HDR_C2         = 8'h37;
    localparam logic [3:0]  STD_PRM_LEN    = 4'h7;
    localparam logic [31:0] SCALE_MAX      = 32'h000f_4240;
    localparam logic [31:0] SCALE_UNITY    = 32'h0000_03e8;
    localparam logic [31:0] MFREQ_MAX      = 32'h001e_8480;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0]  REG_CTRL       = 8'h00;
    localparam logic [7:0]  REG_STATUS     = 8'h04;
    localparam logic [7:0]  REG_WDOG_CNT   = 8'h08;
    localparam logic [7:0]  REG_RST_CNT0   = 8'h0c;
    localparam logic [7:0]  REG_RST_CNT1   = 8'h10;
    localparam logic [7:0]  REG_ALARM_CNT  = 8'h14;
    localparam logic [7:0]  REG_DIAG       = 8'h18;
    localparam logic [7:0]  REG_DIST_OUT   = 8'h1c;
    localparam logic [7:0]  REG_PRM_WIN    = 8'h20;
    // CTRL fields
    localparam int unsigned CTRL_KICK_LO   = 0;
    localparam int unsigned CTRL_SWRST     = 3;
    localparam logic [1:0]  RESP_OKAY      = 2'b00;
    localparam logic [1:0]  RESP_SLVERR    = 2'b10;
    // Reset causes
    localparam int unsigned NCAUSE         = 6;

    typedef enum logic [1:0] {
        TRK_DIST = 2'h0, TRK_CONT = 2'h1, TRK_TDM = 2'h2
    } track_mode_t;

    typedef struct packed {
        logic [1:0]  err_mode;
        track_mode_t trk_mode;
        logic        class2;
        logic        commiss;
        logic [13:0] diag_ivl;
        logic [31:0] scale;
        logic signed [31:0] offset;
        logic [31:0] mfreq;
    } prm_t;

    typedef struct packed {
        logic [15:0] in_edge_spc;
        logic [15:0] out_edge_spc;
        logic [15:0] avg;
        logic [95:0] thresholds;
    } fwd_t;
endpackage : fbs_pkg
`default_nettype wire

/* File: verilog/fbs_supervisor.sv */
// Watchdog, reset counts, slave address, parameters and diagnostics
//
// Our own choices: register access over AXI4-Lite and the register offsets.
`default_nettype none
module fbs_supervisor (
    input  wire logic         mclk,           // 40 MHz clock
    input  wire logic         rst_n,          // Async reset, active low
    input  wire logic         ce,             // Clock enable
    // AXI4-Lite slave
    input  wire logic [7:0]   s_awaddr,       // Write address
    input  wire logic         s_awvalid,      // Write address valid
    output var  logic         s_awready,      // Write address ready
    input  wire logic [31:0]  s_wdata,        // Write data
    input  wire logic [3:0]   s_wstrb,        // Write strobes
    input  wire logic         s_wvalid,       // Write data valid
    output var  logic         s_wready,       // Write data ready
    output var  logic [1:0]   s_bresp,        // Write response
    output var  logic         s_bvalid,       // Write response valid
    input  wire logic         s_bready,       // Write response ready
    input  wire logic [7:0]   s_araddr,       // Read address
    input  wire logic         s_arvalid,      // Read address valid
    output var  logic         s_arready,      // Read address ready
    output var  logic [31:0]  s_rdata,        // Read data
    output var  logic [1:0]   s_rresp,        // Read response
    output var  logic         s_rvalid,       // Read data valid
    input  wire logic         s_rready,       // Read data ready
    // Fieldbus side
    input  wire logic         ssa_valid,      // Set-address request
    input  wire logic [6:0]   ssa_addr,       // Requested address
    input  wire logic [6:0]   nvm_addr,       // Stored address
    input  wire logic         nvm_load,       // Load stored address
    input  wire logic         prm_valid,      // Record received
    input  wire logic [3:0]   prm_len,        // Record length in bytes
    input  wire fbs_pkg::prm_t prm_user,      // User parameters
    input  wire fbs_pkg::fwd_t fwd_in,        // Laser command values
    input  wire logic         diag_req,       // Diag request
    input  wire logic         operate,        // Master in operate state
    input  wire logic         dx_req,         // Data exchange request
    // Internal sources
    input  wire logic [2:0]   task_kick,      // Main loop, laser control, update
    input  wire logic [4:0]   rst_cause,      // Spike, sw, debug, brownout, pin
    input  wire logic         laser_alarm,    // Laser alarm pulse
    input  wire logic         laser_warn,     // Laser warning level
    input  wire logic         laser_err,      // Laser error level
    input  wire logic signed [31:0] dist_raw, // Raw distance
    // Outputs
    output var  logic [6:0]   slave_addr,     // Active slave address
    output var  logic         nvm_we,         // Store address pulse
    output var  logic [6:0]   nvm_wdata,      // Address to store
    output var  logic         prm_ok,         // Parameters accepted
    output var  logic         dx_enable,      // Exchange permitted
    output var  logic         laser_on,       // Laser enable
    output var  logic         laser_retry,    // Reactivation pulse
    output var  logic         diag_send,      // Diag send pulse
    output var  logic         diag_alarm,     // Alarm diagnostic pulse
    output var  logic [5:0]   diag_len,       // Diag length
    output var  logic [7:0]   diag_hdr,       // Header length code
    output var  logic         diag_refresh,   // Diag refresh pulse
    output var  fbs_pkg::fwd_t fwd_out,       // Laser command values
    output var  logic [1:0]   trk_mode,       // Laser trigger mode
    output var  logic [31:0]  mfreq,          // Measure frequency
    output var  logic signed [31:0] dist_out, // Corrected distance
    output var  logic         wdog_rst,       // Watchdog reset pulse
    output var  logic         disp_err        // Local error display
);
    // ==========================================================
    // Watchdog
    logic [25:0] wd_cnt_r;
    logic [2:0]  kick_seen_r;
    logic        sw_kick;
    logic        sw_rst_req;
    wire  [2:0]  kick_all   = kick_seen_r | task_kick | {3{sw_kick}};
    wire         wd_expire  = (wd_cnt_r == 26'(fbs_pkg::WDOG_CYC - 1));

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wd_cnt_r    <= 26'h0;
            kick_seen_r <= 3'h0;
            wdog_rst    <= 1'b0;
        end else if (ce) begin
            wdog_rst <= 1'b0;
            if (kick_all == 3'h7) begin
                wd_cnt_r    <= 26'h0;
                kick_seen_r <= 3'h0;
            end else if (wd_expire) begin
                wd_cnt_r    <= 26'h0;
                kick_seen_r <= 3'h0;
                wdog_rst    <= 1'b1;
            end else begin
                wd_cnt_r    <= wd_cnt_r + 26'h1;
                kick_seen_r <= kick_all;
            end
        end
    end

    // ==========================================================
    // Reset cause counters
    logic [15:0] wd_rst_cnt_r;
    logic [47:0] cause_cnt;
    logic        por_seen_r;
    wire  [5:0]  cause_hit = {~por_seen_r, rst_cause[4:1], rst_cause[0] | sw_rst_req};

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wd_rst_cnt_r <= 16'h0;
            por_seen_r   <= 1'b0;
        end else if (ce) begin
            por_seen_r <= 1'b1;
            if (wdog_rst) begin
                wd_rst_cnt_r <= wd_rst_cnt_r + 16'h1;
            end
        end
    end

    event_counter #(.N(fbs_pkg::NCAUSE)) u_causes (
        .mclk  (mclk),
        .rst_n (rst_n),
        .ce    (ce),
        .hit   (cause_hit),
        .cnt   (cause_cnt)
    );

    // ==========================================================
    // Slave address
    wire ssa_ok = ssa_valid && (ssa_addr <= fbs_pkg::ADDR_MAX);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            slave_addr <= fbs_pkg::ADDR_RST;
            nvm_we     <= 1'b0;
            nvm_wdata  <= 7'h0;
        end else if (ce) begin
            nvm_we <= ssa_ok;
            if (ssa_ok) begin
                slave_addr <= ssa_addr;
                nvm_wdata  <= ssa_addr;
            end else if (nvm_load && nvm_addr <= fbs_pkg::ADDR_MAX) begin
                slave_addr <= nvm_addr;
            end
        end
    end

    // ==========================================================
    // Parameter record
    fbs_pkg::prm_t prm_r;
    wire prm_std  = prm_valid && (prm_len == fbs_pkg::STD_PRM_LEN);
    wire prm_full = prm_valid && (prm_len > fbs_pkg::STD_PRM_LEN);
    wire scale_ok = (prm_user.scale[31] ? -prm_user.scale : prm_user.scale)
                    <= fbs_pkg::SCALE_MAX;
    wire mfreq_ok = prm_user.mfreq <= fbs_pkg::MFREQ_MAX;
    wire ivl_ok   = prm_user.diag_ivl <= fbs_pkg::DIAG_IVL_MAX;
    wire trk_ok   = prm_user.trk_mode != 2'h3;
    wire user_ok  = scale_ok && mfreq_ok && ivl_ok && trk_ok;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prm_r   <= '0;
            prm_ok  <= 1'b0;
            fwd_out <= '0;
        end else if (ce) begin
            if (prm_std) begin
                prm_r       <= '0;
                prm_r.scale <= fbs_pkg::SCALE_UNITY;
                prm_ok      <= 1'b1;
            end else if (prm_full && user_ok) begin
                prm_r   <= prm_user;
                fwd_out <= fwd_in;
                prm_ok  <= 1'b1;
            end
        end
    end

    assign trk_mode = prm_r.trk_mode;
    assign mfreq    = prm_r.mfreq;

    // ==========================================================
    // Data exchange and laser
    wire diag_ext = prm_r.class2 && prm_r.commiss;
    logic alarm_pend_r;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dx_enable   <= 1'b0;
            laser_on    <= 1'b0;
            laser_retry <= 1'b0;
        end else if (ce) begin
            dx_enable   <= prm_ok;
            laser_retry <= 1'b0;
            if (operate && dx_req && prm_ok) begin
                laser_on <= 1'b1;
            end else if (!operate) begin
                laser_on <= 1'b0;
            end
            if (diag_alarm && laser_err && laser_on) begin
                laser_retry <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Distance correction
    logic signed [63:0] scaled;
    logic signed [31:0] corr;
    logic signed [31:0] dist_hold_r;
    assign scaled = (64'(dist_raw) * 64'(signed'(prm_r.scale))) / 64'sd1000;
    assign corr   = 32'(scaled) + prm_r.offset;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dist_out    <= 32'sh0;
            dist_hold_r <= 32'sh0;
        end else if (ce) begin
            if (!laser_err) begin
                dist_out    <= corr;
                dist_hold_r <= corr;
            end else begin
                unique case (prm_r.err_mode)
                    2'h0:    dist_out <= dist_hold_r;
                    2'h1:    dist_out <= 32'sh0;
                    2'h2:    dist_out <= 32'sh7fff_ffff;
                    2'h3:    dist_out <= -32'sh1;
                endcase
            end
        end
    end

    // ==========================================================
    // Diagnostics
    logic [22:0] tick_cnt_r;
    logic [13:0] ivl_cnt_r;
    logic        err_prev_r;
    logic [15:0] alarm_cnt_r;
    wire tick     = (tick_cnt_r == 23'(fbs_pkg::TICK_CYC - 1));
    wire ivl_hit  = tick && (prm_r.diag_ivl != 14'h0)
                    && (ivl_cnt_r + 14'h1 >= prm_r.diag_ivl);
    wire new_err  = (laser_warn || laser_err) && !err_prev_r && diag_ext;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_r   <= 23'h0;
            ivl_cnt_r    <= 14'h0;
            err_prev_r   <= 1'b0;
            alarm_pend_r <= 1'b0;
            alarm_cnt_r  <= 16'h0;
            diag_send    <= 1'b0;
            diag_alarm   <= 1'b0;
            diag_refresh <= 1'b0;
            diag_len     <= fbs_pkg::DIAG_LEN_STD;
            diag_hdr     <= fbs_pkg::HDR_C1;
        end else if (ce) begin
            tick_cnt_r   <= tick ? 23'h0 : tick_cnt_r + 23'h1;
            if (tick) begin
                ivl_cnt_r <= ivl_hit ? 14'h0 : ivl_cnt_r + 14'h1;
            end
            err_prev_r   <= laser_warn || laser_err;
            diag_refresh <= diag_req;
            diag_send    <= ivl_hit;
            // Set wins over the clear taken by the send below
            alarm_pend_r <= laser_alarm || new_err || (alarm_pend_r && !diag_alarm);
            diag_alarm   <= alarm_pend_r && !diag_alarm;
            if (laser_alarm) begin
                alarm_cnt_r <= alarm_cnt_r + 16'h1;
            end
            if (!prm_r.commiss) begin
                diag_len <= fbs_pkg::DIAG_LEN_STD;
            end else if (prm_r.class2) begin
                diag_len <= fbs_pkg::DIAG_LEN_C2;
            end else begin
                diag_len <= fbs_pkg::DIAG_LEN_C1;
            end
            diag_hdr <= diag_ext ? fbs_pkg::HDR_C2 : fbs_pkg::HDR_C1;
        end
    end

    assign disp_err = 1'b0;

    // ==========================================================
    // AXI4-Lite slave, single outstanding access each way
    logic [7:0]  aw_r;
    logic [31:0] w_r;
    logic        aw_have_r;
    logic        w_have_r;
    logic [2:0]  sw_ctrl_r;
    wire do_wr    = aw_have_r && w_have_r && !s_bvalid;
    wire wr_ctrl  = do_wr && (aw_r == fbs_pkg::REG_CTRL);
    assign sw_kick    = wr_ctrl && w_r[fbs_pkg::CTRL_KICK_LO];
    assign sw_rst_req = wr_ctrl && w_r[fbs_pkg::CTRL_SWRST];

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            aw_r      <= 8'h0;
            w_r       <= 32'h0;
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            s_awready <= 1'b1;
            s_wready  <= 1'b1;
            s_bvalid  <= 1'b0;
            s_bresp   <= 2'b00;
            sw_ctrl_r <= 3'h0;
        end else if (ce) begin
            if (s_awvalid && s_awready) begin
                aw_r      <= s_awaddr;
                aw_have_r <= 1'b1;
                s_awready <= 1'b0;
            end
            if (s_wvalid && s_wready) begin
                w_r      <= s_wdata & {{8{s_wstrb[3]}}, {8{s_wstrb[2]}},
                                       {8{s_wstrb[1]}}, {8{s_wstrb[0]}}};
                w_have_r <= 1'b1;
                s_wready <= 1'b0;
            end
            if (do_wr) begin
                s_bvalid  <= 1'b1;
                s_bresp   <= wr_ctrl ? fbs_pkg::RESP_OKAY : fbs_pkg::RESP_SLVERR;
                sw_ctrl_r <= wr_ctrl ? w_r[2:0] : sw_ctrl_r;
                aw_have_r <= 1'b0;
                w_have_r  <= 1'b0;
            end
            if (s_bvalid && s_bready) begin
                s_bvalid  <= 1'b0;
                s_awready <= 1'b1;
                s_wready  <= 1'b1;
            end
        end
    end

    wire [31:0] status_w = {16'h0, slave_addr, laser_on, dx_enable,
                            prm_ok, diag_ext, 2'h0, kick_seen_r};
    logic [31:0] rd_mux;
    logic        rd_hit;
    always_comb begin
        rd_hit = 1'b1;
        unique case (s_araddr)
            fbs_pkg::REG_CTRL:      rd_mux = {29'h0, sw_ctrl_r};
            fbs_pkg::REG_STATUS:    rd_mux = status_w;
            fbs_pkg::REG_WDOG_CNT:  rd_mux = {16'h0, wd_rst_cnt_r};
            fbs_pkg::REG_RST_CNT0:  rd_mux = {8'h0, cause_cnt[23:0]};
            fbs_pkg::REG_RST_CNT1:  rd_mux = {8'h0, cause_cnt[47:24]};
            fbs_pkg::REG_ALARM_CNT: rd_mux = {16'h0, alarm_cnt_r};
            fbs_pkg::REG_DIAG:      rd_mux = {18'h0, diag_hdr, diag_len};
            fbs_pkg::REG_DIST_OUT:  rd_mux = dist_out;
            default: begin
                rd_mux = 32'h0;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_arready <= 1'b1;
            s_rvalid  <= 1'b0;
            s_rdata   <= 32'h0;
            s_rresp   <= 2'b00;
        end else if (ce) begin
            if (s_arvalid && s_arready) begin
                s_arready <= 1'b0;
                s_rvalid  <= 1'b1;
                s_rdata   <= rd_mux;
                s_rresp   <= rd_hit ? fbs_pkg::RESP_OKAY : fbs_pkg::RESP_SLVERR;
            end else if (s_rvalid && s_rready) begin
                s_rvalid  <= 1'b0;
                s_arready <= 1'b1;
            end
        end
    end
endmodule : fbs_supervisor
`default_nettype wire
